// ---- bench/cmc_crc_checker_tb.sv ----
// self-checking testbench for the configuration memory crc checker
`timescale 1ns/100ps
`default_nettype none

module cmc_crc_checker_tb;
    // ------------------------------------------------------------------
    // setup
    // ------------------------------------------------------------------
    localparam int FL = 8;
    localparam int NW = 4;

    logic              core_clk_i      = 1'b0;
    logic              rst_i           = 1'b1;
    logic              reconfig_n_i    = 1'b1;
    logic              cfg_bit_valid_i = 1'b0;
    logic              cfg_bit_i       = 1'b0;
    logic              cfg_ref_valid_i = 1'b0;
    logic [31:0]       cfg_ref_i       = 32'h00000000;
    cmc_pkg::cmc_tap_s tap             = '0;
    logic              poke            = 1'b0;
    logic [1:0]        poke_addr       = 2'h0;
    logic [31:0]       poke_data       = 32'h00000000;
    logic [31:0]       mem_data;
    logic [1:0]        mem_addr;
    logic              mem_rd, cfg_status_n, tdo, crc_err, crc_err_oe, user_mode, pass_done;
    logic [31:0]       result;
    logic              od_err, od_oe;
    logic [31:0]       img [NW];
    logic [31:0]       good, old_ref;
    int                num_errors = 0;
    int                checks     = 0;
    int                cycles     = 0;

    always #2 core_clk_i = ~core_clk_i;

    cmc_crc_checker #(.FRAME_LEN(FL), .CELL_W(32), .WORDS(NW), .DIV_LOG2(0),
                      .OPEN_DRAIN(1'b0)) cmc_crc_checker_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reconfig_n_i(reconfig_n_i),
        .cfg_bit_valid_i(cfg_bit_valid_i), .cfg_bit_i(cfg_bit_i),
        .cfg_ref_valid_i(cfg_ref_valid_i), .cfg_ref_i(cfg_ref_i),
        .cfg_status_n_o(cfg_status_n), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
        .mem_data_i(mem_data), .tap_i(tap), .tdo_o(tdo), .crc_error_o(crc_err),
        .crc_error_oe_o(crc_err_oe), .user_mode_o(user_mode), .pass_done_o(pass_done),
        .check_result_o(result));

    cmc_mem_model #(.CELL_W(32), .WORDS(NW), .AW(2)) cmc_mem_model_inst (
        .clk_i(core_clk_i), .rd_i(mem_rd), .addr_i(mem_addr), .data_o(mem_data),
        .poke_i(poke), .poke_addr_i(poke_addr), .poke_data_i(poke_data));

    // second checker with the open-drain stage; same stimulus, only its pin is compared
    if (1) begin : g_od
        cmc_crc_checker #(.FRAME_LEN(FL), .CELL_W(32), .WORDS(NW), .DIV_LOG2(0),
                          .OPEN_DRAIN(1'b1)) cmc_crc_checker_inst (
            .core_clk_i(core_clk_i), .rst_i(rst_i), .reconfig_n_i(reconfig_n_i),
            .cfg_bit_valid_i(cfg_bit_valid_i), .cfg_bit_i(cfg_bit_i),
            .cfg_ref_valid_i(cfg_ref_valid_i), .cfg_ref_i(cfg_ref_i),
            .cfg_status_n_o(), .mem_rd_o(), .mem_addr_o(), .mem_data_i(mem_data),
            .tap_i(tap), .tdo_o(), .crc_error_o(od_err), .crc_error_oe_o(od_oe),
            .user_mode_o(), .pass_done_o(), .check_result_o());
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard: whole run needs a few hundred cycles
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [15:0] crc16(input logic [FL-1:0] d);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = FL - 1; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? cmc_pkg::CRC16_POLY : 16'h0000);
        end
        return c;
    endfunction

    // one crc over the whole cell image, each word msb first
    function automatic logic [31:0] crc_image();
        logic [31:0] c;
        c = 32'hffffffff;
        for (int w = 0; w < NW; w++) begin
            for (int i = 31; i >= 0; i--) begin
                c = {c[30:0], 1'b0} ^ ((c[31] ^ img[w][i]) ? cmc_pkg::CRC32_POLY : 32'h0);
            end
        end
        return c;
    endfunction

    task automatic put_word(input int a, input logic [31:0] v);
        img[a] = v;
        @(posedge core_clk_i);
        poke <= 1'b1;
        poke_addr <= 2'(a);
        poke_data <= v;
        @(posedge core_clk_i);
        poke <= 1'b0;
    endtask

    task automatic send_frame(input logic [FL-1:0] d, input logic [15:0] c);
        logic [FL+15:0] bits;
        bits = {d, c};
        for (int i = FL + 15; i >= 0; i--) begin
            @(posedge core_clk_i);
            cfg_bit_valid_i <= 1'b1;
            cfg_bit_i <= bits[i];
        end
        @(posedge core_clk_i);
        cfg_bit_valid_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask

    task automatic load_ref(input logic [31:0] r, input logic exp_user);
        @(posedge core_clk_i);
        cfg_ref_valid_i <= 1'b1;
        cfg_ref_i <= r;
        @(posedge core_clk_i);
        cfg_ref_valid_i <= 1'b0;
        #1 check("user_mode", 32'(user_mode), 32'(exp_user));
    endtask

    // waits n pass ends, bounded so a stalled checker is reported
    task automatic wait_pass(input int n);
        int k;
        for (int p = 0; p < n; p++) begin
            k = 0;
            do begin
                @(posedge core_clk_i);
                #1 k++;
            end while (pass_done !== 1'b1 && k < 100);
            check("pass_done", 32'(pass_done), 32'h1);
        end
    endtask

    task automatic scan_ref(input logic [9:0] ir, input logic [31:0] v, input logic exp_flag,
                            output logic [31:0] got);
        @(posedge core_clk_i);
        tap.ir <= ir;
        tap.capture <= 1'b1;
        @(posedge core_clk_i);
        tap.capture <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            tap.shift <= 1'b1;
            tap.tdi <= v[i];
            #1 got[i] = tdo;
            @(posedge core_clk_i);
        end
        tap.shift <= 1'b0;
        tap.tdi <= 1'b0;
        #1 check("flag_mid_scan", 32'(crc_err), 32'(exp_flag));
        check("user_mode_scan", 32'(user_mode), 32'h1);
        @(posedge core_clk_i);
        tap.update <= 1'b1;
        @(posedge core_clk_i);
        tap.update <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1 check("status_rst", 32'(cfg_status_n), 32'h1);
        check("result_rst", result, 32'h0);
        check("flag_rst", {30'h0, crc_err_oe, crc_err}, 32'h2);
        check("od_pin_rst", {30'h0, od_oe, od_err}, 32'h2);
        for (int a = 0; a < NW; a++) begin
            put_word(a, 32'h3c5a0000 + 32'(a * 32'h01010101));
        end
        good = crc_image();
        send_frame(8'hb4, crc16(8'hb4));
        #1 check("status_good", 32'(cfg_status_n), 32'h1);
        load_ref(good, 1'b1);
        wait_pass(2);
        check("result_clean", result, 32'h0);
        check("flag_clean", 32'(crc_err), 32'h0);
        check("od_pin_clean", {30'h0, od_oe, od_err}, 32'h2);
        // corrupt one cell, a later full pass must see it
        put_word(1, img[1] ^ 32'h00000100);
        wait_pass(2);
        check("result_upset", result, crc_image() ^ good);
        check("flag_upset", 32'(crc_err), 32'h1);
        check("pin_upset", {30'h0, crc_err_oe, crc_err}, 32'h3);
        check("od_pin_upset", {30'h0, od_oe, od_err}, 32'h0);
        // memory repaired, flag must still stand until the next pass ends
        put_word(1, img[1] ^ 32'h00000100);
        #1 check("flag_hold", 32'(crc_err), 32'h1);
        wait_pass(2);
        check("flag_restored", 32'(crc_err), 32'h0);
        // inject a wrong reference, read back the right one
        scan_ref(cmc_pkg::REF_LOAD_IR, good ^ 32'h1, 1'b0, old_ref);
        check("scan_out", old_ref, good);
        wait_pass(2);
        check("result_inject", result, 32'h1);
        check("flag_inject", 32'(crc_err), 32'h1);
        scan_ref(cmc_pkg::REF_LOAD_IR, good, 1'b1, old_ref);
        check("scan_back", old_ref, good ^ 32'h1);
        wait_pass(2);
        check("flag_fixed", 32'(crc_err), 32'h0);
        // another instruction must leave the reference alone
        scan_ref(10'h000, good ^ 32'h2, 1'b0, old_ref);
        wait_pass(2);
        check("flag_other_ir", 32'(crc_err), 32'h0);
        // reconfiguration request ends checking
        @(posedge core_clk_i);
        reconfig_n_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        #1 check("user_after_reconf", 32'(user_mode), 32'h0);
        check("result_after_reconf", result, 32'h0);
        @(posedge core_clk_i);
        reconfig_n_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        send_frame(8'h5e, crc16(8'h5e) ^ 16'h0001);
        #1 check("status_bad", 32'(cfg_status_n), 32'h0);
        load_ref(good, 1'b0);
        finish_test();
    end
endmodule

`default_nettype wire

// ---- bench/cmc_mem_model.sv ----
// configuration cell memory model answering the checker's read port
`timescale 1ns/100ps
`default_nettype none

module cmc_mem_model #(
    parameter int CELL_W = 32,
    parameter int WORDS  = 4,
    parameter int AW     = 2
) (
    // clock
    input  wire logic              clk_i,
    // read port from the checker
    input  wire logic              rd_i,
    input  wire logic [AW-1:0]     addr_i,
    output logic [CELL_W-1:0]      data_o,
    // bench access for corrupting and restoring cells
    input  wire logic              poke_i,
    input  wire logic [AW-1:0]     poke_addr_i,
    input  wire logic [CELL_W-1:0] poke_data_i
);
    logic [CELL_W-1:0] cells [WORDS];

    initial data_o = '0;

    // data valid only the cycle after a read; otherwise scrambled so stale values never match
    always @(posedge clk_i) begin
        if (poke_i) begin
            cells[poke_addr_i] <= poke_data_i;
        end
        if (rd_i) begin
            data_o <= cells[addr_i];
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule

`default_nettype wire

// ---- rtl/cmc_crc_checker.sv ----
// configuration memory crc checker: frame check, user-mode scan, reference scan chain
`timescale 1ns/100ps
`default_nettype none

module cmc_crc_checker #(
    parameter int FRAME_LEN = cmc_pkg::FRAME_LEN_DEF,
    parameter int CELL_W    = cmc_pkg::CELL_W_DEF,
    parameter int WORDS     = cmc_pkg::WORDS_DEF,
    parameter int DIV_LOG2  = cmc_pkg::DIV_LOG2_DEF,
    parameter bit OPEN_DRAIN = 1'b0,
    localparam int AW       = (WORDS > 1) ? $clog2(WORDS) : 1,
    localparam int FW       = $clog2(FRAME_LEN + cmc_pkg::CRC16_W)
) (
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // reconfiguration request pin, active low
    input  wire logic              reconfig_n_i,
    // configuration stream
    input  wire logic              cfg_bit_valid_i,
    input  wire logic              cfg_bit_i,
    input  wire logic              cfg_ref_valid_i,
    input  wire logic [31:0]       cfg_ref_i,
    output logic                   cfg_status_n_o,
    // configuration cell memory read port
    output logic                   mem_rd_o,
    output logic [AW-1:0]          mem_addr_o,
    input  wire logic [CELL_W-1:0] mem_data_i,
    // test access
    input  wire cmc_pkg::cmc_tap_s tap_i,
    output logic                   tdo_o,
    // error pin, two signals
    output logic                   crc_error_o,
    output logic                   crc_error_oe_o,
    // status
    output logic                   user_mode_o,
    output logic                   pass_done_o,
    output logic [31:0]            check_result_o
);

    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    if (FRAME_LEN < 1 || WORDS < 1 || CELL_W < 1) begin : g_bad_size
        $error("frame length, word count and cell width must be positive");
    end
    if (DIV_LOG2 < 0 || DIV_LOG2 > cmc_pkg::DIV_LOG2_MAX) begin : g_bad_div
        $error("divider exponent must lie in 0..8");
    end

    localparam logic [FW-1:0] FRAME_DATA_LAST = FW'(FRAME_LEN - 1);
    localparam logic [FW-1:0] FRAME_LAST      = FW'(FRAME_LEN + cmc_pkg::CRC16_W - 1);
    localparam logic [AW-1:0] WORD_LAST       = AW'(WORDS - 1);
    localparam logic [7:0]    DIV_LAST        = 8'((1 << DIV_LOG2) - 1);

    // ------------------------------------------------------------------
    // reconfiguration request synchroniser
    // ------------------------------------------------------------------
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       recfg_reg;
    logic       recfg_next;
    logic       recfg_req;

    // first stage feeds only the second; request changes only when stages two and three agree
    always_comb begin
        sync_next  = {sync_reg[1:0], reconfig_n_i};
        recfg_next = (sync_reg[1] == sync_reg[2]) ? ~sync_reg[2] : recfg_reg;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_reg  <= cmc_pkg::SYNC_IDLE;
            recfg_reg <= 1'b0;
        end else begin
            sync_reg  <= sync_next;
            recfg_reg <= recfg_next;
        end
    end

    assign recfg_req = recfg_reg;

    // ------------------------------------------------------------------
    // check-rate divider
    // ------------------------------------------------------------------
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       tick;

    // slower checking rate is a one-cycle enable, never a derived clock
    always_comb begin
        div_next = (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick = (div_reg == DIV_LAST);

    // ------------------------------------------------------------------
    // reference scan chain
    // ------------------------------------------------------------------
    cmc_pkg::cmc_state_e state_reg;
    logic [31:0]         shift_reg;
    logic [31:0]         shift_next;
    logic [31:0]         ref_reg;
    logic                scan_act;

    // the instruction works only in user mode; logic keeps running meanwhile
    assign scan_act = (state_reg == cmc_pkg::CMC_ST_USER) &&
                      (tap_i.ir == cmc_pkg::REF_LOAD_IR);               // RL16

    // shadow chain so a half-shifted pattern never reaches the compare
    always_comb begin
        shift_next = shift_reg;
        if (scan_act && tap_i.capture) begin
            shift_next = ref_reg;                                        // RL13
        end else if (scan_act && tap_i.shift) begin
            shift_next = {tap_i.tdi, shift_reg[31:1]};                   // RL13
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            shift_reg <= cmc_pkg::REFERENCE_RST;
        end else begin
            shift_reg <= shift_next;
        end
    end

    assign tdo_o = shift_reg[0];   // lsb leaves first, from a flop

    // ------------------------------------------------------------------
    // control: frame check, reference, user-mode pass
    // ------------------------------------------------------------------
    logic [FW-1:0]   bit_cnt_reg, bit_cnt_next;
    logic [15:0]     crc16_reg, crc16_next;
    logic [15:0]     rx16_reg, rx16_next;
    logic            status_n_reg, status_n_next;
    cmc_pkg::cmc_state_e state_next;
    logic [31:0]     ref_next;
    logic [AW-1:0]   addr_reg, addr_next;
    logic            rd_pend_reg, rd_pend_next;
    logic [31:0]     crc32_reg, crc32_next;
    logic [31:0]     sig_reg, sig_next;
    logic            err_reg, err_next;
    logic            done_reg, done_next;
    logic [31:0]     fold;
    logic [15:0]     rx_full;
    logic            frame_bad;

    always_comb begin
        bit_cnt_next  = bit_cnt_reg;
        crc16_next    = crc16_reg;
        rx16_next     = rx16_reg;
        status_n_next = status_n_reg;
        state_next    = state_reg;
        ref_next      = ref_reg;
        addr_next     = addr_reg;
        rd_pend_next  = 1'b0;
        crc32_next    = crc32_reg;
        sig_next      = sig_reg;
        err_next      = err_reg;
        done_next     = 1'b0;
        frame_bad     = 1'b0;
        rx_full       = {rx16_reg[14:0], cfg_bit_i};
        fold          = crc32_reg;
        // fold one cell word into the running crc, msb first
        for (int i = CELL_W - 1; i >= 0; i--) begin
            fold = cmc_pkg::cmc_crc32_bit(fold, mem_data_i[i]);          // RL17
        end
        case (state_reg)
            cmc_pkg::CMC_ST_CONFIG: begin
                if (cfg_bit_valid_i) begin
                    bit_cnt_next = bit_cnt_reg + FW'(1);
                    if (bit_cnt_reg <= FRAME_DATA_LAST) begin
                        crc16_next = cmc_pkg::cmc_crc16_bit(crc16_reg, cfg_bit_i); // RL5
                    end else begin
                        rx16_next = rx_full;                             // RL4
                        if (bit_cnt_reg == FRAME_LAST) begin             // RL7
                            bit_cnt_next = '0;
                            crc16_next   = cmc_pkg::CRC16_INIT;
                            if (rx_full != crc16_reg) begin
                                frame_bad     = 1'b1;
                                status_n_next = 1'b0;                    // RL6
                                state_next    = cmc_pkg::CMC_ST_FAIL;
                            end
                        end
                    end
                end else if (cfg_ref_valid_i && bit_cnt_reg == '0) begin
                    ref_next   = cfg_ref_i;                              // RL11
                    state_next = cmc_pkg::CMC_ST_USER;
                    crc32_next = cmc_pkg::CRC32_INIT;
                end
            end
            cmc_pkg::CMC_ST_USER: begin
                if (scan_act && tap_i.update) begin
                    ref_next = shift_reg;                                // RL20 RL14
                end
                if (tick && !rd_pend_reg) begin
                    rd_pend_next = 1'b1;                                 // RL15
                end
                if (rd_pend_reg) begin
                    crc32_next = fold;                                   // RL3
                    if (addr_reg == WORD_LAST) begin
                        // whole memory covered: compare and restart
                        sig_next   = fold ^ ref_reg;                     // RL10 RL12
                        err_next   = |(fold ^ ref_reg);                  // RL19
                        crc32_next = cmc_pkg::CRC32_INIT;
                        addr_next  = '0;
                        done_next  = 1'b1;                               // RL18
                    end else begin
                        addr_next = addr_reg + AW'(1);
                    end
                end
            end
            cmc_pkg::CMC_ST_FAIL: begin
                state_next = cmc_pkg::CMC_ST_FAIL;   // held until reconfiguration
            end
            default: begin
                state_next = cmc_pkg::CMC_ST_CONFIG;
            end
        endcase
    end

    // reconfiguration request acts like reset on these control registers; synchroniser, divider and scan chain ignore it
    always_ff @(posedge core_clk_i) begin
        if (rst_i || recfg_req) begin
            bit_cnt_reg  <= '0;
            crc16_reg    <= cmc_pkg::CRC16_INIT;
            rx16_reg     <= 16'h0000;
            status_n_reg <= 1'b1;
            state_reg    <= cmc_pkg::CMC_ST_CONFIG;
            ref_reg      <= cmc_pkg::REFERENCE_RST;
            addr_reg     <= '0;
            rd_pend_reg  <= 1'b0;
            crc32_reg    <= cmc_pkg::CRC32_INIT;
            sig_reg      <= cmc_pkg::RESULT_RST;
            err_reg      <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            bit_cnt_reg  <= bit_cnt_next;
            crc16_reg    <= crc16_next;
            rx16_reg     <= rx16_next;
            status_n_reg <= status_n_next;
            state_reg    <= state_next;
            ref_reg      <= ref_next;
            addr_reg     <= addr_next;
            rd_pend_reg  <= rd_pend_next;
            crc32_reg    <= crc32_next;
            sig_reg      <= sig_next;
            err_reg      <= err_next;
            done_reg     <= done_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // read strobe is combinational, address comes from a flop
    assign mem_rd_o       = (state_reg == cmc_pkg::CMC_ST_USER) && tick && !rd_pend_reg;
    assign mem_addr_o     = addr_reg;
    assign cfg_status_n_o = status_n_reg;
    assign user_mode_o    = (state_reg == cmc_pkg::CMC_ST_USER);
    assign pass_done_o    = done_reg;
    assign check_result_o = sig_reg;                                     // RL8
    // open drain releases the pin for a high, so the pull-up shows the error
    assign crc_error_o    = OPEN_DRAIN ? 1'b0 : err_reg;                 // RL1 RL2 RL9
    assign crc_error_oe_o = OPEN_DRAIN ? ~err_reg : 1'b1;               // RL2

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_flag_from_result: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL9
        err_reg == (check_result_o != 32'h00000000))
        else $error("error flag disagrees with result register");

    a_flag_holds_pass: assert property (@(posedge core_clk_i) disable iff (rst_i || recfg_req) // RL19
        (err_reg && !done_next) |=> err_reg)
        else $error("error flag dropped before the pass ended");

    a_pin_stage: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL2
        OPEN_DRAIN ? (!crc_error_o && crc_error_oe_o == !err_reg)
                   : (crc_error_oe_o && crc_error_o == err_reg))
        else $error("error pin stage drives the wrong way");

    a_ref_stable: assert property (@(posedge core_clk_i) disable iff (rst_i || recfg_req) // RL20
        (user_mode_o && !(scan_act && tap_i.update)) |=> $stable(ref_reg))
        else $error("reference changed outside scan update");

    a_ref_update: assert property (@(posedge core_clk_i) disable iff (rst_i || recfg_req) // RL13
        (scan_act && tap_i.update) |=> ref_reg == $past(shift_reg))
        else $error("scan update did not load reference");

    a_tdo_shift: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL13
        (scan_act && tap_i.shift && !tap_i.capture) |=> tdo_o == $past(shift_reg[1]))
        else $error("scan chain did not advance");

    a_frame_status: assert property (@(posedge core_clk_i) disable iff (rst_i || recfg_req) // RL6
        frame_bad |=> !cfg_status_n_o ##1 !cfg_status_n_o)
        else $error("frame mismatch did not pull status low");

    a_ref_load: assert property (@(posedge core_clk_i) disable iff (rst_i || recfg_req) // RL11
        (state_reg == cmc_pkg::CMC_ST_CONFIG && !cfg_bit_valid_i && cfg_ref_valid_i &&
         bit_cnt_reg == '0) |=> (user_mode_o && ref_reg == $past(cfg_ref_i)))
        else $error("reference not loaded at configuration end");

    a_scan_no_halt: assert property (@(posedge core_clk_i) disable iff (rst_i || recfg_req) // RL15
        (user_mode_o && scan_act && rd_pend_reg) |=>
        (pass_done_o || mem_addr_o != $past(mem_addr_o)))
        else $error("scan access stalled the memory scan");

    a_pass_repeats: assert property (@(posedge core_clk_i) disable iff (rst_i || recfg_req) // RL18
        pass_done_o |-> ##[0:300] mem_rd_o)
        else $error("checking did not restart after a pass");

endmodule

`default_nettype wire

// ---- rtl/cmc_pkg.sv ----
// constants, types and crc step functions for the configuration memory crc checker
//
// Summary of operation
// [RL1] dedicated error flag output reports user-mode checking
// [RL2] error pin push-pull, open-drain by build option
// [RL3] one 32-bit crc over all cell memory
// [RL4] each frame's 16-bit crc shifted in after frame
// [RL5] frame crc computed while frame shifts in
// [RL6] frame crc mismatch pulls status low
// [RL7] frame length is a per-device parameter
// [RL8] separate 32-bit result and reference registers
// [RL9] non-zero result register drives error flag high
// [RL10] result holds computed crc against reference, zero ok
// [RL11] reference loaded from stream at configuration end
// [RL12] reference feeds the user-mode compare circuit
// [RL13] reference forms 32-bit scan chain under instruction
// [RL14] host overwrite of reference injects reported error
// [RL15] scan access never pauses normal operation
// [RL16] instruction code 00 0001 0101, tdi to tdo
// [RL17] ieee 802 32-bit generator polynomial
// [RL18] checking repeats until reconfiguration request
// [RL19] flag holds through next pass, clears if clean
// [RL20] reference changes only at scan update

package cmc_pkg;

    // ------------------------------------------------------------------
    // widths, codes and reset values
    // ------------------------------------------------------------------
    localparam int          CRC32_W        = 32;
    localparam int          CRC16_W        = 16;
    localparam int          IR_W           = 10;
    localparam logic [9:0]  REF_LOAD_IR    = 10'h015;
    localparam logic [31:0] CRC32_POLY     = 32'h04c11db7;
    localparam logic [31:0] CRC32_INIT     = 32'hffffffff;
    localparam logic [15:0] CRC16_POLY     = 16'h8005;   // frame polynomial, plain default
    localparam logic [15:0] CRC16_INIT     = 16'hffff;
    localparam logic [31:0] RESULT_RST     = 32'h00000000;
    localparam logic [31:0] REFERENCE_RST  = 32'h00000000;
    localparam logic [2:0]  SYNC_IDLE      = 3'h7;       // request pin idles high
    localparam int          FRAME_LEN_DEF  = 64;
    localparam int          CELL_W_DEF     = 32;
    localparam int          WORDS_DEF      = 64;
    localparam int          DIV_LOG2_DEF   = 0;
    localparam int          DIV_LOG2_MAX   = 8;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMC_ST_CONFIG,
        CMC_ST_USER,
        CMC_ST_FAIL
    } cmc_state_e;

    // test access port strobes from a tap on core_clk; capture and update are one-cycle pulses, shift stays high for one cycle per bit
    typedef struct packed {
        logic [9:0] ir;
        logic       capture;
        logic       shift;
        logic       update;
        logic       tdi;
    } cmc_tap_s;

    // ------------------------------------------------------------------
    // one serial crc step each, msb first
    // ------------------------------------------------------------------
    function automatic logic [15:0] cmc_crc16_bit(input logic [15:0] c, input logic b);
        cmc_crc16_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC16_POLY : 16'h0000);
    endfunction

    function automatic logic [31:0] cmc_crc32_bit(input logic [31:0] c, input logic b);
        cmc_crc32_bit = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC32_POLY : 32'h00000000);
    endfunction

endpackage
